/* File: core/vfd_map.svh */
// constants for the display command interpreter: codes, defaults, timing
`ifndef VFD_MAP_SVH
`define VFD_MAP_SVH

// clock rate and time to cycle conversion
`define CLK_MHZ        50
`define CYC_US(t)      ((t) * `CLK_MHZ)
`define CYC_MS(t)      ((t) * 1000 * `CLK_MHZ)

// busy times, in the unit named
`define T_BASE_US      50
`define T_CLR_US       2500
`define T_LAST_AREA_MS 1
`define T_RESET_US     500
`define T_BYTE_US      250
`define T_CHAR_US      500
`define T_ERASE_MS     250
`define T_EE_MS        40
`define T_PORT_MS      80
`define T_WINDEF_US    60
`define T_BASE_CYC     `CYC_US(`T_BASE_US)

// single byte command codes
`define C_CR           8'h0d
`define C_CLR_EOL      8'h0e
`define C_TEST         8'h0f
`define C_CURSOR       8'h10
`define C_SET_AREA     8'h11
`define C_CLR_AREA     8'h12
`define C_INV_AREA     8'h13
`define C_SET_BOX      8'h14
`define C_CLR_BOX      8'h15
`define C_SET_PIX      8'h16
`define C_CLR_PIX      8'h17
`define C_GFX          8'h18
`define C_RESET        8'h19
`define C_WMODE        8'h1a
`define C_ESC          8'h1b
`define C_FONT_MINI    8'h1c
`define C_FONT_5X7     8'h1d
`define C_FONT_10X14   8'h1e
`define C_GFX_AREA     8'h1f
`define C_CHAR_MIN     8'h20

// escape sub-codes
`define E_MACRO_MAX    8'h07
`define E_BRIGHT_MIN   8'hf8
`define E_ERASE        8'h4d
`define E_LOCK         8'h4c
`define E_UNLOCK       8'h55
`define E_CSUM         8'h43
`define E_HV_ON        8'h50
`define E_HV_OFF       8'h46
`define E_HEX_ON       8'h48
`define E_HEX_OFF      8'h42
`define E_SER          8'h49
`define E_PORT_DIR     8'h44
`define E_PORT_SET     8'h4f
`define E_PORT_RD      8'h52
`define E_KEYSCAN      8'h4b
`define E_WIN1         8'h80
`define E_WIN2         8'h81
`define E_WIN_DEF      8'h82
`define E_WIN_MODE     8'h83
`define E_WIN_SHOW     8'h84
`define E_WIN_KILL     8'h85

// reset values and fields
`define HEX_PFX        8'h60
`define WMODE_RST      8'h00
`define BRIGHT_RST     3'h7
`define SER_RST        8'h02
`define DIR_RST        8'hff
`define MACRO_LIMIT    10'h1d8
`define FONT_MINI      2'h0
`define FONT_5X7       2'h1
`define FONT_10X14     2'h2
`define FW_SMALL       8'h06
`define FW_LARGE       8'h0b
`define WM_MOVE_V      6
`define WM_DIR_BACK    5
`define GFX_ROW        8'h08

`endif

/* File: core/vfd_pkg.sv */
// types shared by the display command interpreter
package vfd_pkg;

  // parser states
  typedef enum logic [2:0] {
    S_IDLE, S_ESC, S_PAR, S_LEN, S_DATA, S_BUSY, S_TEST
  } state_type;

  // operations handed to the display engine
  typedef enum logic [4:0] {
    OP_NONE, OP_CLR_EOL, OP_SET_AREA, OP_CLR_AREA, OP_INV_AREA, OP_SET_BOX,
    OP_CLR_BOX, OP_SET_PIX, OP_CLR_PIX, OP_GFX, OP_GFX_AREA, OP_RESET,
    OP_CHAR, OP_MACRO, OP_ERASE, OP_WIN_DEF, OP_WIN_MODE, OP_WIN_SHOW,
    OP_WIN_KILL
  } op_kind_type;

  // one operation with its parameters
  typedef struct packed {
    op_kind_type kind;
    logic        win;
    logic [7:0]  p0;
    logic [7:0]  p1;
    logic [7:0]  p2;
    logic [7:0]  p3;
  } op_type;

endpackage

/* File: core/vfd_cmd.sv */
// byte stream command interpreter for the graphic display module
`timescale 1ns/1ps
`include "vfd_map.svh"

// Contract
// - 10H x y sets cursor; 0DH zeroes x, keeps y.
// - 0EH clears from cursor to display end, busy about 2.5 ms.
// - 0FH enters self-test until next byte; clears checksum.
// - 11H/12H/13H plus rectangle light, blank or invert it; moves cursor; 1 ms added.
// - 14H/15H plus rectangle draw or erase outline only; moves cursor.
// - 16H lights, 17H blanks the pixel at the cursor.
// - 18H length data or 1FH area data write graphics, 250 us per byte.
// - 19H restores defaults: clear, 5x7 font, mode 00H, level 7, power on.
// - 1AH plus byte sets write mode fields, all defaulting zero.
// - escape macro number length data stores macro, 472 bytes max; 4DH erases all.
// - escape F8H..FFH selects brightness; F8H off, FFH max and default.
// - escape 4CH locks, 55H unlocks stored settings; 40 ms added.
// - all received bytes summed; escape 43H returns low byte then clears.
// - escape 50H turns high voltage on (default), 46H off keeping contents.
// - escape 48H enables hex receive with 60H prefix, 42H disables; on at reset.
// - escape 49H data stores serial settings used from next reset.
// - settings bits 3,1,0 pick baud rate, 010 default.
// - escape 44H data sets port direction, outputs low, pull-ups on, 80 ms.
// - escape 4FH data sets outputs or pull-ups; 52H returns port state.
// - escape 4BH selects key scanning, saved, 40 ms added.
// - 1CH/1DH/1EH select font; 20H..FFH draw a character, 500 us.
// - escape 80H..85H select, define, mode, show and kill windows.
module vfd_cmd
  import vfd_pkg::*;
#(
  parameter int T_CLR_CYC    = `CYC_US(`T_CLR_US),
  parameter int T_AREA_CYC   = `T_BASE_CYC + `CYC_MS(`T_LAST_AREA_MS),
  parameter int T_RESET_CYC  = `CYC_US(`T_RESET_US),
  parameter int T_BYTE_CYC   = `CYC_US(`T_BYTE_US),
  parameter int T_CHAR_CYC   = `CYC_US(`T_CHAR_US),
  parameter int T_ERASE_CYC  = `CYC_MS(`T_ERASE_MS),
  parameter int T_EE_CYC     = `T_BASE_CYC + `CYC_MS(`T_EE_MS),
  parameter int T_PORT_CYC   = `T_BASE_CYC + `CYC_MS(`T_PORT_MS),
  parameter int T_WINDEF_CYC = `T_BASE_CYC + `CYC_US(`T_WINDEF_US)
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_valid_i,
  output logic            rx_ready_o,
  output logic [7:0]      tx_data_o,
  output logic            tx_valid_o,
  input  wire logic       tx_ready_i,
  output op_type          op_o,
  output logic            op_valid_o,
  output logic [7:0]      dat_o,
  output logic            dat_valid_o,
  output logic            dat_macro_o,
  output logic            busy_o,
  output logic            test_mode_o,
  output logic [7:0]      cur_x_o,
  output logic [7:0]      cur_y_o,
  output logic [1:0]      font_o,
  output logic [7:0]      wmode_o,
  output logic [2:0]      bright_o,
  output logic            hv_on_o,
  output logic            hex_mode_o,
  output logic            ee_lock_o,
  input  wire logic [7:0] ser_boot_i,
  output logic [7:0]      ser_save_o,
  output logic [7:0]      ser_cfg_o,
  output logic [2:0]      baud_sel_o,
  input  wire logic [7:0] port_i,
  output logic [7:0]      port_o,
  output logic [7:0]      port_oe_o,
  output logic [7:0]      port_pu_o,
  output logic            keyscan_o,
  output logic            win_sel_o
);

  // two-entry receive buffer
  logic [7:0] mem_q [2];
  logic       wp_q, rp_q, rdy_q;
  logic [1:0] cnt_q, cnt_d;
  // parser state
  state_type  st_q, ret_q, ret_c;
  logic [7:0] cmd_q, par_q [4], pa [4], raw, b;
  logic       esc_q, take, pv, hex_eat, ex, dat, ld, follows;
  logic [2:0] pidx_q, need_q, need;
  logic [8:0] key;
  logic [15:0] dcnt_q, dn;
  logic [23:0] bcnt_q, ld_cyc;
  logic [1:0] hex_st_q;
  logic [3:0] nib_q, hb;
  logic [8:0] aw;
  // block state
  logic [7:0] sum_q, x_q, y_q, wm_q, ss_q, sc_q, dir_q, pout_q, p1_q, p2_q;
  logic [7:0] tx_q, dat_q;
  logic [1:0] font_q;
  logic [2:0] br_q;
  logic       hv_q, hex_q, lock_q, ks_q, win_q, busy_q, txv_q, opv_q, datv_q, mac_q;
  logic [9:0] mused_q;
  op_type     op_q;

  // parameter count per command key {escape, code}; 5 = length byte, 6 = escape
  function automatic logic [2:0] need_of(input logic [8:0] k);
    if (k == {1'b0, `C_CURSOR}) return 3'h2;
    if ((!k[8] && k[7:0] >= `C_SET_AREA && k[7:0] <= `C_CLR_BOX) ||
        k == {1'b0, `C_GFX_AREA} || k == {1'b1, `E_WIN_DEF}) return 3'h4;
    if (k == {1'b0, `C_GFX} || (k[8] && k[7:0] <= `E_MACRO_MAX)) return 3'h5;
    if (k == {1'b0, `C_ESC}) return 3'h6;
    if (k == {1'b0, `C_WMODE} || k == {1'b1, `E_SER} || k == {1'b1, `E_PORT_DIR} ||
        k == {1'b1, `E_PORT_SET} || k == {1'b1, `E_WIN_MODE}) return 3'h1;
    return 3'h0;
  endfunction

  // busy time after a command with no data phase
  function automatic logic [23:0] busy_of(input logic [8:0] k);
    logic [7:0] c;
    c = k[7:0];
    if (!k[8]) begin
      if (c == `C_CLR_EOL) return 24'(T_CLR_CYC);
      if (c >= `C_SET_AREA && c <= `C_CLR_BOX) return 24'(T_AREA_CYC);
      if (c == `C_RESET) return 24'(T_RESET_CYC);
      if (c >= `C_CHAR_MIN) return 24'(T_CHAR_CYC);
    end else begin
      if (c == `E_ERASE) return 24'(T_ERASE_CYC);
      if (c == `E_LOCK || c == `E_UNLOCK || c == `E_KEYSCAN) return 24'(T_EE_CYC);
      if (c == `E_PORT_DIR) return 24'(T_PORT_CYC);
      if (c == `E_WIN_DEF) return 24'(T_WINDEF_CYC);
    end
    return 24'(`T_BASE_CYC);
  endfunction

  // buffer occupancy and flop-driven ready
  always_comb begin
    cnt_d = cnt_q + 2'((rx_valid_i && rdy_q) ? 1 : 0) - 2'(take ? 1 : 0);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= 2'h0;
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != 2'h2);
      if (rx_valid_i && rdy_q) wp_q <= ~wp_q;
      if (take) rp_q <= ~rp_q;
    end
  end

  // buffer storage
  always_ff @(posedge clk_i) begin
    if (rx_valid_i && rdy_q) mem_q[wp_q] <= rx_data_i;
  end

  // byte decode: hex front end, command key and what happens this cycle
  always_comb begin
    raw = mem_q[rp_q];
    take = (cnt_q != 2'h0) && (st_q != S_BUSY);
    hb = raw[6] ? raw[3:0] + 4'h9 : raw[3:0];
    b = (hex_st_q == 2'h2) ? {nib_q, hb} : raw;
    hex_eat = hex_q && (st_q != S_TEST) &&
              (hex_st_q == 2'h1 || (hex_st_q == 2'h0 && raw == `HEX_PFX));
    pv = take && (st_q != S_TEST) && !hex_eat;
    unique case (st_q)
      S_IDLE:  key = {1'b0, b};
      S_ESC:   key = {1'b1, b};
      default: key = {esc_q, cmd_q};
    endcase
    need = need_of(key);
    for (int i = 0; i < 4; i++) begin
      pa[i] = (st_q == S_PAR && pidx_q == 3'(i)) ? b : par_q[i];
    end
    aw = {1'b0, pa[2]} - {1'b0, pa[0]} + 9'h1;
    // bytes in a graphic area: columns times 8-dot rows
    dn = (st_q == S_LEN) ? {8'h0, b} : 16'(aw) * 16'(9'((pa[3] - pa[1]) >> 3) + 9'h1);
    ex = pv && (((st_q == S_IDLE || st_q == S_ESC) && need == 3'h0) ||
                (st_q == S_PAR && pidx_q == need_q - 3'h1) || st_q == S_LEN);
    follows = ex && dn != 16'h0 && (st_q == S_LEN || key == {1'b0, `C_GFX_AREA});
    dat = pv && st_q == S_DATA;
    ld = (ex && key != {1'b0, `C_TEST}) || dat;
    ld_cyc = dat ? 24'(T_BYTE_CYC) : (follows ? 24'(`T_BASE_CYC) : busy_of(key));
    ret_c = (follows || (dat && dcnt_q > 16'h1)) ? S_DATA : S_IDLE;
  end

  // hex prefix: 60H then two hex digits form one byte
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hex_st_q <= 2'h0;
      nib_q    <= 4'h0;
    end else if (take && st_q != S_TEST) begin
      if (hex_st_q == 2'h1) nib_q <= hb;
      hex_st_q <= hex_eat ? hex_st_q + 2'h1 : 2'h0;
    end
  end

  // parser sequence: opcode, escape, parameters, length, data, busy
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q   <= S_IDLE;
      ret_q  <= S_IDLE;
      cmd_q  <= 8'h0;
      esc_q  <= 1'b0;
      pidx_q <= 3'h0;
      need_q <= 3'h0;
      dcnt_q <= 16'h0;
      bcnt_q <= 24'h0;
      for (int i = 0; i < 4; i++) par_q[i] <= 8'h0;
    end else begin
      unique case (st_q)
        S_BUSY: begin
          bcnt_q <= bcnt_q - 24'h1;
          if (bcnt_q <= 24'h1) st_q <= ret_q;
        end
        S_TEST: if (take) st_q <= S_IDLE;
        S_IDLE, S_ESC: if (pv) begin
          cmd_q  <= b;
          esc_q  <= (st_q == S_ESC);
          pidx_q <= 3'h0;
          need_q <= need;
          if (need == 3'h6) st_q <= S_ESC;
          else if (need == 3'h5) st_q <= S_LEN;
          else if (need != 3'h0) st_q <= S_PAR;
        end
        S_PAR: if (pv) begin
          par_q[pidx_q[1:0]] <= b;
          pidx_q <= pidx_q + 3'h1;
        end
        S_LEN, S_DATA: ;
      endcase
      if (ex) dcnt_q <= dn;
      if (dat) dcnt_q <= dcnt_q - 16'h1;
      if (ld) begin
        st_q   <= S_BUSY;
        bcnt_q <= ld_cyc;
        ret_q  <= ret_c;
      end
      if (ex && key == {1'b0, `C_TEST}) st_q <= S_TEST;
    end
  end

  // busy flag tracks the wait count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) busy_q <= 1'b0;
    else busy_q <= ld || (st_q == S_BUSY && bcnt_q > 24'h1);
  end

  // running checksum of every byte taken; a clearing command wins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) sum_q <= 8'h0;
    else if (ex && (key == {1'b1, `E_CSUM} || key == {1'b0, `C_TEST})) sum_q <= 8'h0;
    else if (take) sum_q <= sum_q + raw;
  end

  // port pin synchroniser
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      p1_q <= 8'h0;
      p2_q <= 8'h0;
    end else begin
      p1_q <= port_i;
      p2_q <= p1_q;
    end
  end

  // replies to the host; a new reply wins over the handshake
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      txv_q <= 1'b0;
      tx_q  <= 8'h0;
    end else if (ex && key == {1'b1, `E_CSUM}) begin
      txv_q <= 1'b1;
      tx_q  <= sum_q + raw;
    end else if (ex && key == {1'b1, `E_PORT_RD}) begin
      txv_q <= 1'b1;
      tx_q  <= p2_q;
    end else if (tx_ready_i) begin
      txv_q <= 1'b0;
    end
  end

  // settings, cursor and operation issue
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      x_q <= 8'h0;
      y_q <= 8'h0;
      font_q <= `FONT_5X7;
      wm_q <= `WMODE_RST;
      br_q <= `BRIGHT_RST;
      hv_q <= 1'b1;
      hex_q <= 1'b1;
      lock_q <= 1'b0;
      ss_q <= `SER_RST;
      sc_q <= ser_boot_i;
      dir_q <= `DIR_RST;
      pout_q <= 8'h0;
      ks_q <= 1'b0;
      win_q <= 1'b0;
      mused_q <= 10'h0;
      opv_q <= 1'b0;
      op_q <= '0;
      datv_q <= 1'b0;
      dat_q <= 8'h0;
      mac_q <= 1'b0;
    end else begin
      opv_q  <= 1'b0;
      datv_q <= 1'b0;
      if (ex) begin
        op_q <= '{kind: OP_NONE, win: win_q, p0: pa[0], p1: pa[1], p2: pa[2], p3: pa[3]};
        opv_q <= (key != {1'b0, `C_TEST}); // self-test has no busy wait
        if (!key[8]) begin
          unique case (key[7:0])
            `C_CR: x_q <= 8'h0;
            `C_CLR_EOL: op_q.kind <= OP_CLR_EOL;
            `C_CURSOR: begin
              x_q <= pa[0];
              y_q <= pa[1];
            end
            `C_SET_AREA, `C_CLR_AREA, `C_INV_AREA, `C_SET_BOX, `C_CLR_BOX: begin
              op_q.kind <= op_kind_type'(5'(OP_SET_AREA) + 5'(key[2:0] - 3'h1));
              x_q <= pa[2];
              y_q <= pa[3];
            end
            `C_SET_PIX: op_q.kind <= OP_SET_PIX;
            `C_CLR_PIX: op_q.kind <= OP_CLR_PIX;
            `C_GFX: op_q.kind <= OP_GFX;
            `C_GFX_AREA: op_q.kind <= OP_GFX_AREA;
            `C_RESET: begin
              op_q.kind <= OP_RESET;
              font_q <= `FONT_5X7;
              wm_q <= `WMODE_RST;
              br_q <= `BRIGHT_RST;
              hv_q <= 1'b1;
            end
            `C_WMODE: wm_q <= pa[0];
            `C_FONT_MINI: font_q <= `FONT_MINI;
            `C_FONT_5X7: font_q <= `FONT_5X7;
            `C_FONT_10X14: font_q <= `FONT_10X14;
            default: if (key[7:0] >= `C_CHAR_MIN) begin
              op_q.kind <= OP_CHAR;
              op_q.p0 <= b;
              x_q <= x_q + ((font_q == `FONT_10X14) ? `FW_LARGE : `FW_SMALL);
            end
          endcase
        end else begin
          unique case (key[7:0])
            `E_ERASE: if (!lock_q) begin
              op_q.kind <= OP_ERASE;
              mused_q <= 10'h0;
            end
            `E_LOCK: lock_q <= 1'b1;
            `E_UNLOCK: lock_q <= 1'b0;
            `E_HV_ON: hv_q <= 1'b1;
            `E_HV_OFF: hv_q <= 1'b0;
            `E_HEX_ON: hex_q <= 1'b1;
            `E_HEX_OFF: hex_q <= 1'b0;
            `E_SER: if (!lock_q) ss_q <= pa[0];
            `E_PORT_DIR: begin
              dir_q <= pa[0];
              pout_q <= pa[0];
              ks_q <= 1'b0;
            end
            `E_PORT_SET: pout_q <= pa[0];
            `E_KEYSCAN: ks_q <= 1'b1;
            `E_WIN1, `E_WIN2: win_q <= key[0];
            `E_WIN_DEF: op_q.kind <= OP_WIN_DEF;
            `E_WIN_MODE: op_q.kind <= OP_WIN_MODE;
            `E_WIN_SHOW: op_q.kind <= OP_WIN_SHOW;
            `E_WIN_KILL: op_q.kind <= OP_WIN_KILL;
            default: begin
              if (key[7:0] >= `E_BRIGHT_MIN) br_q <= key[2:0];
              if (key[7:0] <= `E_MACRO_MAX) begin
                op_q.kind <= OP_MACRO;
                op_q.p0 <= cmd_q;
                op_q.p1 <= b;
              end
            end
          endcase
        end
      end
      if (dat) begin
        dat_q <= b;
        mac_q <= esc_q;
        if (esc_q) begin
          datv_q <= !lock_q && mused_q < `MACRO_LIMIT;
          if (!lock_q && mused_q < `MACRO_LIMIT) mused_q <= mused_q + 10'h1;
        end else begin
          datv_q <= 1'b1;
          if (wm_q[`WM_MOVE_V]) y_q <= wm_q[`WM_DIR_BACK] ? y_q - `GFX_ROW : y_q + `GFX_ROW;
          else x_q <= wm_q[`WM_DIR_BACK] ? x_q - 8'h1 : x_q + 8'h1;
        end
      end
    end
  end

  // outputs straight from flops; test flag, port enables and pull-ups through gates
  assign rx_ready_o  = rdy_q;
  assign tx_data_o   = tx_q;
  assign tx_valid_o  = txv_q;
  assign op_o        = op_q;
  assign op_valid_o  = opv_q;
  assign dat_o       = dat_q;
  assign dat_valid_o = datv_q;
  assign dat_macro_o = mac_q;
  assign busy_o      = busy_q;
  assign test_mode_o = (st_q == S_TEST);
  assign cur_x_o     = x_q;
  assign cur_y_o     = y_q;
  assign font_o      = font_q;
  assign wmode_o     = wm_q;
  assign bright_o    = br_q;
  assign hv_on_o     = hv_q;
  assign hex_mode_o  = hex_q;
  assign ee_lock_o   = lock_q;
  assign ser_save_o  = ss_q;
  assign ser_cfg_o   = sc_q;
  assign baud_sel_o  = {sc_q[3], sc_q[1:0]};
  assign port_o      = pout_q;
  assign port_oe_o   = ~dir_q;
  assign port_pu_o   = dir_q & pout_q;
  assign keyscan_o   = ks_q;
  assign win_sel_o   = win_q;

endmodule

/* File: sim/vfd_cmd_asserts.sv */
// concurrent checks on the command interpreter ports
`timescale 1ns/1ps
module vfd_cmd_asserts
  import vfd_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       rx_ready_o,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_valid_o,
  input wire logic       tx_ready_i,
  input wire op_type     op_o,
  input wire logic       op_valid_o,
  input wire logic       dat_valid_o,
  input wire logic       busy_o,
  input wire logic [1:0] font_o,
  input wire logic [7:0] wmode_o,
  input wire logic [2:0] bright_o,
  input wire logic       hv_on_o,
  input wire logic       hex_mode_o,
  input wire logic [7:0] ser_cfg_o,
  input wire logic [2:0] baud_sel_o,
  input wire logic [7:0] port_oe_o,
  input wire logic [7:0] port_pu_o
);
  // one clock domain, reset disables all checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_op_busy: assert property (op_valid_o |-> busy_o) else $error("op without busy");
  chk_op_pulse: assert property (op_valid_o |=> !op_valid_o) else $error("op too long");
  chk_dat_busy: assert property (dat_valid_o |-> busy_o) else $error("data without busy");
  chk_reset_vals: assert property ($rose(rst_n_i) |-> !rx_ready_o && bright_o == 3'h7
    && font_o == 2'h1 && hv_on_o && hex_mode_o && wmode_o == 8'h00 ##1 rx_ready_o)
    else $error("bad values after reset");
  chk_reset_cmd: assert property (op_valid_o && op_o.kind == OP_RESET |-> ##[0:1]
    (bright_o == 3'h7 && font_o == 2'h1 && wmode_o == 8'h00 && hv_on_o))
    else $error("defaults not restored");
  chk_baud_map: assert property (baud_sel_o == {ser_cfg_o[3], ser_cfg_o[1], ser_cfg_o[0]})
    else $error("baud select mismatch");
  chk_pull_dir: assert property ((port_oe_o & port_pu_o) == 8'h00)
    else $error("pull-up on driven line");
  chk_reply_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o
    && $stable(tx_data_o)) else $error("reply dropped");
endmodule

bind vfd_cmd vfd_cmd_asserts u_chk (
  .clk_i, .rst_n_i, .rx_ready_o, .tx_data_o, .tx_valid_o, .tx_ready_i, .op_o, .op_valid_o,
  .dat_valid_o, .busy_o, .font_o, .wmode_o, .bright_o, .hv_on_o, .hex_mode_o, .ser_cfg_o,
  .baud_sel_o, .port_oe_o, .port_pu_o
);

/* File: sim/vfd_host.sv */
// host side model: offers command bytes, takes reply bytes
`timescale 1ns/1ps
module vfd_host (
  input  wire logic       clk_i,
  input  wire logic       ready_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic [7:0]      data_o,
  output logic            valid_o,
  output logic            tx_ready_o
);
  // idle link, slow reply side
  initial begin
    data_o = 8'h00;
    valid_o = 1'b0;
    tx_ready_o = 1'b0;
  end

  // bytes of one command, valid held until each is taken
  task automatic send(input logic [39:0] b, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      data_o <= b[8*i+:8];
      valid_o <= 1'b1;
      @(posedge clk_i);
      for (int k = 0; k < 9999 && !ready_i; k++) @(posedge clk_i);
      if (!ready_i) begin
        tb_top.bad_count++;
        $display("[FAIL] byte taken expected 1 seen 0");
      end
    end
    valid_o <= 1'b0;
    data_o <= ~b[7:0]; // no stale byte on a released line
  endtask

  // accept one reply byte
  task automatic reply(output logic [7:0] d);
    for (int k = 0; k < 9999 && !tx_valid_i; k++) @(posedge clk_i);
    if (!tx_valid_i) begin
      tb_top.bad_count++;
      $display("[FAIL] reply valid expected 1 seen 0");
    end
    tx_ready_o <= 1'b1;
    @(posedge clk_i);
    d = tx_data_i;
    tx_ready_o <= 1'b0;
  endtask
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the display command interpreter
`timescale 1ns/1ps
module tb_top;
  import vfd_pkg::*;

  // bytes sent, output picked, value expected
  typedef struct packed {
    logic [39:0] b;
    logic [2:0]  n;
    logic [3:0]  s;
    logic [7:0]  e;
  } row_type;

  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  ser_boot_i = 8'h02;
  logic [7:0]  port_i = 8'h3c;
  logic [7:0]  rx_data_i, tx_data_o, dat_o, cur_x_o, cur_y_o, wmode_o, d, d_last;
  logic [7:0]  ser_save_o, ser_cfg_o, port_o, port_oe_o, port_pu_o;
  logic        rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, op_valid_o, dat_valid_o;
  logic        dat_macro_o, busy_o, test_mode_o, hv_on_o, hex_mode_o, ee_lock_o;
  logic        keyscan_o, win_sel_o;
  logic [1:0]  font_o;
  logic [2:0]  bright_o, baud_sel_o;
  op_type      op_o;
  op_kind_type last_op;
  int          bad_count, samples_checked, dat_cnt, n0;

  row_type rows[$] = '{
    '{0, 0, 4, 7}, '{0, 0, 2, 1}, '{0, 0, 5, 1}, '{0, 0, 6, 1},
    '{0, 0, 10, 2}, '{0, 0, 15, 2}, '{0, 0, 11, 0},
    '{'h100509, 3, 0, 5}, '{0, 0, 1, 9}, '{'h0d, 1, 0, 0}, '{0, 0, 1, 9},
    '{'h1c, 1, 2, 0}, '{'h1e, 1, 2, 2}, '{'h1aa5, 2, 3, 'ha5},
    '{'h1bf8, 2, 4, 0}, '{'h1bf9, 2, 4, 1}, '{'h1b46, 2, 5, 0},
    '{'h1b42, 2, 6, 0}, '{'h1b48, 2, 6, 1}, '{'h1a606333, 4, 3, 'hc3},
    '{'h19, 1, 3, 0}, '{0, 0, 2, 1}, '{0, 0, 4, 7}, '{0, 0, 5, 1},
    '{'h1b4c, 2, 7, 1}, '{'h1b55, 2, 7, 0}, '{'h1b81, 2, 9, 1}, '{'h1b80, 2, 9, 0},
    '{'h1b4b, 2, 8, 1}, '{'h1b440f, 3, 11, 'hf0}, '{0, 0, 12, 'h0f}, '{0, 0, 8, 0},
    '{'h1b4f33, 3, 12, 'h03}, '{'h1b4917, 3, 10, 'h17}, '{0, 0, 14, 2},
    '{'h1102030a0b, 5, 0, 'h0a}, '{0, 0, 1, 'h0b}, '{0, 0, 13, OP_SET_AREA},
    '{'h1201010202, 5, 13, OP_CLR_AREA}, '{'h1301010202, 5, 13, OP_INV_AREA},
    '{'h1401010708, 5, 1, 8}, '{'h1501010708, 5, 13, OP_CLR_BOX},
    '{'h16, 1, 13, OP_SET_PIX}, '{'h17, 1, 13, OP_CLR_PIX}, '{'h0e, 1, 13, OP_CLR_EOL},
    '{'h41, 1, 13, OP_CHAR}, '{'h1b8302, 3, 13, OP_WIN_MODE}, '{'h1b84, 2, 13, OP_WIN_SHOW},
    '{'h1b85, 2, 13, OP_WIN_KILL}, '{'h1b4d, 2, 13, OP_ERASE}
  };

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  vfd_cmd #(
    .T_CLR_CYC(20), .T_AREA_CYC(20), .T_ERASE_CYC(20), .T_EE_CYC(20), .T_PORT_CYC(20)
  ) u_vfd_cmd (
    .clk_i, .rst_n_i, .rx_data_i, .rx_valid_i, .rx_ready_o, .tx_data_o, .tx_valid_o,
    .tx_ready_i, .op_o, .op_valid_o, .dat_o, .dat_valid_o, .dat_macro_o, .busy_o,
    .test_mode_o, .cur_x_o, .cur_y_o, .font_o, .wmode_o, .bright_o, .hv_on_o, .hex_mode_o,
    .ee_lock_o, .ser_boot_i, .ser_save_o, .ser_cfg_o, .baud_sel_o, .port_i, .port_o,
    .port_oe_o, .port_pu_o, .keyscan_o, .win_sel_o
  );

  vfd_host u_vfd_host (
    .clk_i, .ready_i(rx_ready_o), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .data_o(rx_data_i), .valid_o(rx_valid_i), .tx_ready_o(tx_ready_i)
  );

  // last operation kind, data byte count and value
  always @(posedge clk_i) begin
    if (op_valid_o === 1'b1) last_op <= op_o.kind;
    if (dat_valid_o === 1'b1) dat_cnt <= dat_cnt + 1;
    if (dat_valid_o === 1'b1) d_last <= dat_o;
  end

  function automatic logic [7:0] obs(input logic [3:0] s);
    case (s)
      4'h0: return cur_x_o;
      4'h1: return cur_y_o;
      4'h2: return {6'h00, font_o};
      4'h3: return wmode_o;
      4'h4: return {5'h00, bright_o};
      4'h5: return {7'h00, hv_on_o};
      4'h6: return {7'h00, hex_mode_o};
      4'h7: return {7'h00, ee_lock_o};
      4'h8: return {7'h00, keyscan_o};
      4'h9: return {7'h00, win_sel_o};
      4'ha: return ser_save_o;
      4'hb: return port_oe_o;
      4'hc: return port_pu_o;
      4'hd: return {3'h0, last_op};
      4'he: return ser_cfg_o;
      default: return {5'h00, baud_sel_o};
    endcase
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // waits until the interpreter has stayed idle a few cycles
  task automatic idle();
    int c;
    c = 0;
    for (int k = 0; k < 30000 && c < 5; k++) begin
      @(posedge clk_i);
      c = busy_o ? 0 : c + 1;
    end
    if (c < 5) begin
      bad_count++;
      $display("[FAIL] idle expected 5 seen %0d", c);
    end
  endtask

  task automatic rst();
    rst_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
  endtask

  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // table rows, then test mode, replies, data and reset cases
  initial begin
    rst();
    foreach (rows[i]) begin
      if (rows[i].n != 3'h0) begin
        u_vfd_host.send(rows[i].b, rows[i].n);
        idle();
      end
      chk($sformatf("row %0d", i), rows[i].e, obs(rows[i].s));
    end
    chk("port out", 8'h33, port_o);
    u_vfd_host.send('h0f, 1);
    idle();
    chk("test on", 8'h01, {7'h00, test_mode_o});
    u_vfd_host.send('h00, 1);
    idle();
    chk("test off", 8'h00, {7'h00, test_mode_o});
    for (int j = 0; j < 2; j++) begin
      u_vfd_host.send('h1b43, 2);
      idle();
      chk("reply held", 8'h01, {7'h00, tx_valid_o});
      u_vfd_host.reply(d);
      chk("sum", 8'h5e, d);
    end
    u_vfd_host.send('h1b52, 2);
    u_vfd_host.reply(d);
    chk("port", 8'h3c, d);
    idle();
    n0 = dat_cnt;
    u_vfd_host.send('h1802aa55, 4);
    idle();
    chk("gfx count", 8'h02, 8'(dat_cnt - n0));
    chk("gfx last", 8'h55, d_last);
    chk("gfx op", OP_GFX, {3'h0, last_op});
    n0 = dat_cnt;
    u_vfd_host.send('h1f00000007, 5);
    idle();
    u_vfd_host.send('h5a, 1);
    idle();
    chk("area count", 8'h01, 8'(dat_cnt - n0));
    chk("area op", OP_GFX_AREA, {3'h0, last_op});
    chk("gfx flag", 8'h00, {7'h00, dat_macro_o});
    u_vfd_host.send('h1b4c, 2);
    idle();
    n0 = dat_cnt;
    u_vfd_host.send('h1b030177, 4);
    idle();
    chk("locked macro", 8'h00, 8'(dat_cnt - n0));
    u_vfd_host.send('h1b55, 2);
    idle();
    u_vfd_host.send('h1b030177, 4);
    idle();
    chk("macro count", 8'h01, 8'(dat_cnt - n0));
    chk("macro byte", 8'h77, d_last);
    chk("macro flag", 8'h01, {7'h00, dat_macro_o});
    chk("macro num", 8'h03, op_o.p0);
    for (int c = 0; c < 8; c++) begin
      ser_boot_i <= {4'h0, c[2], 1'b0, c[1:0]};
      rst();
      chk("baud", 8'(c), {5'h00, baud_sel_o});
    end
    chk("cfg", 8'h0b, ser_cfg_o);
    complete_run();
  end

  // watchdog
  initial begin
    repeat (300000) @(posedge clk_i);
    bad_count++;
    complete_run();
  end
endmodule
